// File: logic/sfci_flash_if.v
// Serial command interface of a configuration flash, with its FIFO.
// Assumes one 40 MHz clock; link pins are asynchronous and sampled here;
// the memory ports are synchronous to clock; read data must follow the address within the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "sfci_consts.vh"

////////////////////////////////////////////////////////////////////////////
module sfci_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = `SFCI_FIFO_DEPTH,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clock,
  input  wire             reset_n,
  // Fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // Drain side
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_q;
  reg [AW-1:0]    rdPtr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  assign inReady  = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_q];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always @(posedge clock) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                   wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                   rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // sfci_fifo

////////////////////////////////////////////////////////////////////////////
// What this block does
// R1: All fields shift most significant bit first
// R2: Sample input on each rising serial clock
// R3: Opcode 06 sets write-enable latch bit 1
// R4: Opcode 04 clears write-enable latch
// R5: Opcode 05 returns status on data out
// R6: Opcode 01 takes one byte, sets protect bits
// R7: Read outputs repeat while select stays low
// R8: Page write keeps only last 256 bytes
// R9: Host may end reads after any bit
// R10: Write-type frames off byte boundary rejected
// R11: Busy cycle refuses memory access, continues
// R12: Latch clears on reset, disable, completion
// R13: No write or erase without latch set
// R14: Status bit 0 shows busy, always readable
// R15: Bulk erase only with all protect bits clear
// R16: Protected sectors block page write, erase
// R17: Eight-sector protection map from three bits
// R18: Four-sector protection map from two bits
// R19: Write status must end after data byte
// R20: Valid write status starts timed busy cycle
// R21: Opcode 03 reads with auto-incrementing address
// R22: Opcode 02 page write, address and data
// R23: Opcode c7 erases whole memory
// R24: Opcode d8 erases addressed sector
// R25: Sector erase three address bytes, identifier dummies
// R26: Unknown opcodes change nothing
module sfci_flash_if #(
  parameter EIGHT_SECTORS = 1,
  parameter ADDR_W        = 19,
  parameter [7:0] ID_CODE = 8'h5a, // Arbitrary value
  parameter WS_CYCLES     = `SFCI_T_WS_US * (`SFCI_CLK_KHZ / 1000),
  parameter PW_CYCLES     = `SFCI_T_PW_US * (`SFCI_CLK_KHZ / 1000),
  parameter BE_CYCLES     = `SFCI_T_BE_MS * `SFCI_CLK_KHZ,
  parameter SE_CYCLES     = `SFCI_T_SE_MS * `SFCI_CLK_KHZ,
  parameter FIFO_DEPTH    = `SFCI_FIFO_DEPTH
) (
  // Clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // Serial link pins
  input  wire        chipSelectN,
  input  wire        serialClock,
  input  wire        serialDataIn,
  output reg         serialDataOut,
  // Memory read port
  output reg  [23:0] memRdAddr,
  input  wire [7:0]  memRdData,
  // Memory write port
  output reg         memWrValid,
  input  wire        memWrReady,
  output reg  [23:0] memWrAddr,
  output reg  [7:0]  memWrData,
  // Erase port
  output reg         eraseValid,
  output reg         eraseAll,
  output reg  [2:0]  eraseSector,
  // Status view
  output reg  [7:0]  flashStatus
);
  localparam [2:0]  ST_IDLE   = 3'b001;
  localparam [2:0]  ST_COMMIT = 3'b010;
  localparam [2:0]  ST_TIMED  = 3'b100;
  localparam [23:0] ADDR_MASK = (24'h1 << ADDR_W) - 24'h1;

  reg        csS1_q, csS2_q, csS3_q;
  reg        sclkS1_q, sclkS2_q, sclkS3_q;
  reg        sdiS1_q, sdiS2_q;
  reg [2:0]  bitCnt_q;
  reg [2:0]  byteCnt_q;
  reg [7:0]  shiftIn_q;
  reg [7:0]  opcode_q;
  reg [23:0] addr_q;
  reg [7:0]  outShift_q;
  reg        sending_q;
  reg        readOk_q;
  reg        rdLoad_q;
  reg        wel_q;
  reg [2:0]  bp_q;
  reg [2:0]  state_q;
  reg [31:0] timer_q;
  reg [7:0]  col_q;
  reg [7:0]  idx_q;
  reg [15:0] commitBase_q;
  reg [255:0] pageMask_q;
  reg [7:0]  pageBuf [0:255];

  wire       sclkRise = sclkS2_q & ~sclkS3_q;
  wire       sclkFall = ~sclkS2_q & sclkS3_q;
  wire       csLow    = ~csS2_q;
  wire       csFall   = ~csS2_q & csS3_q;
  wire       csRise   = csS2_q & ~csS3_q;
  wire       byteDone = csLow & sclkRise & (bitCnt_q == 3'h7);
  wire [7:0] rxByte   = {shiftIn_q[6:0], sdiS2_q};
  wire       boundary = (bitCnt_q == 3'h0);
  wire       busy     = ~state_q[0];
  wire [7:0] statusVal = {3'h0, bp_q, wel_q, busy}; // R14
  wire [2:0] addrSector = EIGHT_SECTORS ? addr_q[18:16] :
                          {1'b0, addr_q[16:15]};
  wire [23:0] rdNext  = (memRdAddr + 24'h1) & ADDR_MASK; // R21
  wire [7:0] opNow    = (byteCnt_q == 3'h0) ? rxByte : opcode_q;
  wire       canWrite = boundary & wel_q & ~busy; // R10 R11 R13
  wire       fifoInValid;
  wire       fifoInReady;
  wire [31:0] fifoInData;
  wire       fifoOutValid;
  wire       fifoOutReady;
  wire [31:0] fifoOutData;
  wire       commitStep;
  wire       sectProt;

  function isProtected;
    input [2:0] bp;
    input [2:0] sector;
    begin
      if (EIGHT_SECTORS != 0) begin
        case (bp) // R17
          3'h0:    isProtected = 1'b0;
          3'h1:    isProtected = (sector == 3'h7);
          3'h2:    isProtected = (sector >= 3'h6);
          3'h3:    isProtected = (sector >= 3'h4);
          default: isProtected = 1'b1;
        endcase
      end else begin
        case (bp[1:0]) // R18
          2'h0:    isProtected = 1'b0;
          2'h1:    isProtected = (sector == 3'h3);
          2'h2:    isProtected = (sector >= 3'h2);
          default: isProtected = 1'b1;
        endcase
      end
    end
  endfunction

  assign sectProt    = isProtected(bp_q, addrSector); // R16
  assign fifoInValid = state_q[1] & pageMask_q[idx_q];
  assign fifoInData  = {commitBase_q, idx_q, pageBuf[idx_q]};
  assign commitStep  = state_q[1] & (~pageMask_q[idx_q] | fifoInReady);
  assign fifoOutReady = ~memWrValid | memWrReady;

  sfci_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .clock    (clock),
    .reset_n  (reset_n),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  //////////////////////////////////////////////////////////////////////////
  // Page buffer: wrapping column keeps the last 256 bytes
  always @(posedge clock) begin
    if (byteDone && !busy && opcode_q == `SFCI_OP_PAGE_WRITE &&
        byteCnt_q >= `SFCI_DATA_FIRST) begin
      pageBuf[col_q] <= rxByte; // R8
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and serial shifting
  always @(posedge clock) begin
    if (!reset_n) begin
      csS1_q     <= 1'b1;
      csS2_q     <= 1'b1;
      csS3_q     <= 1'b1;
      sclkS1_q   <= 1'b0;
      sclkS2_q   <= 1'b0;
      sclkS3_q   <= 1'b0;
      sdiS1_q    <= 1'b0;
      sdiS2_q    <= 1'b0;
      bitCnt_q   <= 3'h0;
      byteCnt_q  <= 3'h0;
      shiftIn_q  <= 8'h00;
      opcode_q   <= 8'h00;
      addr_q     <= 24'h0;
      col_q      <= 8'h00;
      pageMask_q <= 256'h0;
    end else begin
      csS1_q   <= chipSelectN;
      csS2_q   <= csS1_q;
      csS3_q   <= csS2_q;
      sclkS1_q <= serialClock;
      sclkS2_q <= sclkS1_q;
      sclkS3_q <= sclkS2_q;
      sdiS1_q  <= serialDataIn;
      sdiS2_q  <= sdiS1_q;
      if (csFall) begin
        bitCnt_q  <= 3'h0;
        byteCnt_q <= 3'h0;
        if (!busy) begin
          pageMask_q <= 256'h0;
        end
      end else if (csLow && sclkRise) begin
        shiftIn_q <= rxByte; // R1 R2
        bitCnt_q  <= bitCnt_q + 3'h1;
      end
      if (byteDone) begin
        if (byteCnt_q != 3'h7) begin
          byteCnt_q <= byteCnt_q + 3'h1;
        end
        if (byteCnt_q == 3'h0) begin
          opcode_q <= rxByte;
        end else if (byteCnt_q <= `SFCI_ADDR_BYTES) begin
          addr_q <= {addr_q[15:0], rxByte}; // R25
        end
        if (byteCnt_q == `SFCI_ADDR_BYTES) begin
          col_q <= rxByte;
        end
        if (!busy && opcode_q == `SFCI_OP_PAGE_WRITE &&
            byteCnt_q >= `SFCI_DATA_FIRST) begin
          pageMask_q[col_q] <= 1'b1; // R8 R22
          col_q             <= col_q + 8'h01;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Data out: loaded at byte ends, shifted on falling serial clock
  always @(posedge clock) begin
    if (!reset_n) begin
      serialDataOut <= 1'b0;
      outShift_q    <= 8'h00;
      sending_q     <= 1'b0;
      readOk_q      <= 1'b0;
      rdLoad_q      <= 1'b0;
      memRdAddr     <= 24'h0;
    end else begin
      rdLoad_q <= 1'b0;
      if (!csLow) begin
        serialDataOut <= 1'b0; // R9
        sending_q     <= 1'b0;
        readOk_q      <= 1'b0;
      end else if (byteDone) begin
        case (opNow)
          `SFCI_OP_RD_STATUS: begin
            outShift_q <= statusVal; // R5 R7
            sending_q  <= 1'b1;
          end
          `SFCI_OP_RD_BYTES: begin
            if (byteCnt_q == `SFCI_ADDR_BYTES && !busy) begin
              memRdAddr <= {addr_q[15:0], rxByte} & ADDR_MASK; // R21
              rdLoad_q  <= 1'b1;
              readOk_q  <= 1'b1;
            end else if (byteCnt_q > `SFCI_ADDR_BYTES && readOk_q) begin
              rdLoad_q <= 1'b1; // R7
            end
          end
          `SFCI_OP_RD_IDENT: begin
            if (byteCnt_q >= `SFCI_ADDR_BYTES && !busy) begin
              outShift_q <= ID_CODE; // R25 R11
              sending_q  <= 1'b1;
            end
          end
          default: begin
            sending_q <= sending_q;
          end
        endcase
      end else if (sclkFall && sending_q) begin
        serialDataOut <= outShift_q[7]; // R1
        outShift_q    <= {outShift_q[6:0], 1'b0};
      end
      if (rdLoad_q) begin
        outShift_q <= memRdData;
        sending_q  <= 1'b1;
        memRdAddr  <= rdNext;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status, self-timed cycles and commit to memory
  always @(posedge clock) begin
    if (!reset_n) begin
      wel_q        <= 1'b0; // R12
      bp_q         <= 3'h0;
      state_q      <= ST_IDLE;
      timer_q      <= 32'h0;
      idx_q        <= 8'h00;
      commitBase_q <= 16'h0;
      eraseValid   <= 1'b0;
      eraseAll     <= 1'b0;
      eraseSector  <= 3'h0;
      memWrValid   <= 1'b0;
      memWrAddr    <= 24'h0;
      memWrData    <= 8'h00;
      flashStatus  <= `SFCI_STATUS_RESET;
    end else begin
      flashStatus <= statusVal;
      eraseValid  <= 1'b0;
      if (timer_q != 32'h0) begin
        timer_q <= timer_q - 32'h1;
      end
      if (fifoOutValid && fifoOutReady) begin
        memWrValid <= 1'b1;
        memWrAddr  <= fifoOutData[31:8] & ADDR_MASK;
        memWrData  <= fifoOutData[7:0];
      end else if (memWrReady) begin
        memWrValid <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          idx_q <= 8'h00;
        end
        ST_COMMIT: begin
          if (commitStep) begin
            idx_q <= idx_q + 8'h01;
            if (idx_q == 8'hff) begin
              state_q <= ST_TIMED;
            end
          end
        end
        ST_TIMED: begin
          if (timer_q == 32'h0 && !fifoOutValid && !memWrValid) begin
            state_q <= ST_IDLE; // R14
            wel_q   <= 1'b0; // R12
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      if (csRise && byteCnt_q != 3'h0) begin
        case (opcode_q) // R26
          `SFCI_OP_WR_ENABLE: begin
            if (boundary) begin
              wel_q <= 1'b1; // R3 R10
            end
          end
          `SFCI_OP_WR_DISABLE: begin
            if (boundary) begin
              wel_q <= 1'b0; // R4 R12
            end
          end
          `SFCI_OP_WR_STATUS: begin
            if (canWrite && byteCnt_q == `SFCI_WS_BYTES) begin // R19
              bp_q    <= {addr_q[`SFCI_ST_BP_HI] & (EIGHT_SECTORS != 0),
                          addr_q[`SFCI_ST_BP_HI-1:`SFCI_ST_BP_LO]}; // R6
              timer_q <= WS_CYCLES; // R20
              state_q <= ST_TIMED;
            end
          end
          `SFCI_OP_PAGE_WRITE: begin
            if (canWrite && byteCnt_q >= `SFCI_DATA_FIRST + 3'h1 &&
                !sectProt) begin // R22 R16
              commitBase_q <= addr_q[23:8];
              timer_q      <= PW_CYCLES;
              state_q      <= ST_COMMIT;
            end
          end
          `SFCI_OP_BULK_ERASE: begin
            if (canWrite && byteCnt_q == 3'h1 && bp_q == 3'h0) begin // R15
              eraseValid  <= 1'b1; // R23
              eraseAll    <= 1'b1;
              eraseSector <= 3'h0;
              timer_q    <= BE_CYCLES;
              state_q    <= ST_TIMED;
            end
          end
          `SFCI_OP_SECT_ERASE: begin
            if (canWrite && byteCnt_q == `SFCI_DATA_FIRST &&
                !sectProt) begin // R24 R16
              eraseValid  <= 1'b1;
              eraseAll    <= 1'b0;
              eraseSector <= addrSector;
              timer_q     <= SE_CYCLES;
              state_q     <= ST_TIMED;
            end
          end
          default: begin
            wel_q <= wel_q;
          end
        endcase
      end
    end
  end
endmodule // sfci_flash_if
`default_nettype wire

// File: logic/sfci_consts.vh
// Constants of the serial flash command interface.
// Assumes inclusion by bare name from the design files.
`ifndef SFCI_CONSTS_VH
`define SFCI_CONSTS_VH
`define SFCI_OP_WR_ENABLE   8'h06
`define SFCI_OP_WR_DISABLE  8'h04
`define SFCI_OP_RD_STATUS   8'h05
`define SFCI_OP_WR_STATUS   8'h01
`define SFCI_OP_RD_BYTES    8'h03
`define SFCI_OP_PAGE_WRITE  8'h02
`define SFCI_OP_BULK_ERASE  8'hc7
`define SFCI_OP_SECT_ERASE  8'hd8
`define SFCI_OP_RD_IDENT    8'hab
`define SFCI_ST_BUSY        0
`define SFCI_ST_WEL         1
`define SFCI_ST_BP_LO       2
`define SFCI_ST_BP_HI       4
`define SFCI_STATUS_RESET   8'h00
`define SFCI_ADDR_BYTES     3'h3
`define SFCI_DATA_FIRST     3'h4
`define SFCI_WS_BYTES       3'h2
`define SFCI_CLK_KHZ        40000
`define SFCI_T_WS_US        5000
`define SFCI_T_PW_US        1500
`define SFCI_T_BE_MS        5000
`define SFCI_T_SE_MS        2000
`define SFCI_FIFO_DEPTH     16
`endif

// File: dv/sfci_flash_if_asserts.sv
// Assertion checker for the flash command interface.
// Assumes binding to sfci_flash_if; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module sfci_flash_if_asserts (
  // Clock, reset and link
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        chipSelectN,
  input wire logic        serialDataOut,
  // Memory and erase side
  input wire logic        memWrValid,
  input wire logic        memWrReady,
  input wire logic [23:0] memWrAddr,
  input wire logic [7:0]  memWrData,
  input wire logic        eraseValid,
  input wire logic        eraseAll,
  input wire logic [2:0]  eraseSector,
  input wire logic [7:0]  flashStatus
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [2:0] bp;
  logic       hit;
  assign bp = flashStatus[4:2];
  assign hit = bp[2] || (bp == 3'h1 && eraseSector == 3'h7) ||
               (bp == 3'h2 && eraseSector[2:1] == 2'h3) ||
               (bp == 3'h3 && eraseSector[2]);
  a_status_upper_zero: assert property (
    flashStatus[7:5] == 3'h0) else $error("status upper bits set");
  a_erase_single_pulse: assert property (
    eraseValid |=> !eraseValid) else $error("erase pulse too long");
  a_erase_needs_latch: assert property (
    eraseValid |-> flashStatus[1]) else $error("erase without latch");
  a_bulk_unprotected: assert property (
    eraseValid && eraseAll |-> bp == 3'h0) else $error("bulk erase bad");
  a_sector_unprotected: assert property (
    eraseValid && !eraseAll |-> !hit) else $error("protected erase");
  a_erase_sets_busy: assert property (
    eraseValid |-> ##[1:3] flashStatus[0]) else $error("no busy");
  a_write_in_busy: assert property (
    memWrValid |-> flashStatus[0]) else $error("write while idle");
  a_write_holds: assert property (
    memWrValid && !memWrReady |=> memWrValid && $stable(memWrAddr)
    && $stable(memWrData)) else $error("write request dropped");
  a_out_idle: assert property (
    chipSelectN [*6] |-> !serialDataOut) else $error("out not idle");
  a_latch_clears_end: assert property (
    $fell(flashStatus[0]) |-> !flashStatus[1]) else $error("latch kept");
  cover property (eraseValid && eraseAll);
  cover property (eraseValid && !eraseAll);
  cover property (memWrValid && !memWrReady);
  cover property ($fell(flashStatus[0]));
endmodule // sfci_flash_if_asserts

bind sfci_flash_if sfci_flash_if_asserts u_chk (
  .clock(clock), .reset_n(reset_n), .chipSelectN(chipSelectN),
  .serialDataOut(serialDataOut), .memWrValid(memWrValid),
  .memWrReady(memWrReady), .memWrAddr(memWrAddr),
  .memWrData(memWrData), .eraseValid(eraseValid), .eraseAll(eraseAll),
  .eraseSector(eraseSector), .flashStatus(flashStatus));
`default_nettype wire

// File: dv/sfci_host_model.sv
// Host model driving the serial link of the flash interface.
// Assumes a 40 MHz clock; link clock period is eight cycles.
`timescale 1ns/1ps
`default_nettype none
module sfci_host_model (
  // Clock
  input  wire logic clock,
  // Link pins
  output var  logic chipSelectN,
  output var  logic serialClock,
  output var  logic serialDataIn,
  input  wire logic serialDataOut
);
  initial begin
    chipSelectN = 1'b1;
    serialClock = 1'b0;
    serialDataIn = 1'b0;
  end
  // Data moves after the fall, read back at the rise
  task automatic shiftBit(input logic b, output logic r);
    serialDataIn <= b;
    repeat (4) @(posedge clock);
    serialClock <= 1'b1;
    r = serialDataOut;
    repeat (4) @(posedge clock);
    serialClock <= 1'b0;
  endtask
  task automatic shiftByte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) shiftBit(b[i], r[i]);
  endtask
  task automatic select();
    @(posedge clock);
    chipSelectN <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  // Released data line toggles so no stale level is read
  task automatic deselect();
    repeat (4) @(posedge clock);
    chipSelectN <= 1'b1;
    serialDataIn <= ~serialDataIn;
    repeat (8) @(posedge clock);
  endtask
endmodule // sfci_host_model
`default_nettype wire

// File: dv/sfci_flash_if_tb_top.sv
// Self-checking bench for the serial flash command interface.
// Assumes the host model on the link and a behavioural memory here.
`timescale 1ns/1ps
`default_nettype none
`include "sfci_consts.vh"
module sfci_flash_if_tb_top;
  localparam int WS = 2000;
  // Identifier value is arbitrary; the design's default is kept
  localparam logic [7:0] ID = 8'h5a;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        memWrReady = 1'b0;
  wire [7:0]   memRdData;
  wire         chipSelectN, serialClock, serialDataIn, serialDataOut;
  wire         memWrValid, eraseValid, eraseAll;
  wire [23:0]  memRdAddr, memWrAddr;
  wire [7:0]   memWrData, flashStatus;
  wire [2:0]   eraseSector;
  int          errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          seed = 32'hfe93;
  logic [7:0]  tx[$];
  logic [7:0]  rx[$];
  logic [31:0] expW[$];
  logic [3:0]  expE[$];

  always #12.5 clock = ~clock;
  // Short self-timed cycles keep the run brief
  sfci_flash_if #(.WS_CYCLES(WS), .PW_CYCLES(WS), .BE_CYCLES(50),
    .SE_CYCLES(50)) dut (.clock(clock),
    .reset_n(reset_n), .chipSelectN(chipSelectN),
    .serialClock(serialClock), .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut), .memRdAddr(memRdAddr),
    .memRdData(memRdData), .memWrValid(memWrValid),
    .memWrReady(memWrReady), .memWrAddr(memWrAddr),
    .memWrData(memWrData), .eraseValid(eraseValid),
    .eraseAll(eraseAll), .eraseSector(eraseSector),
    .flashStatus(flashStatus));
  sfci_host_model host (.clock(clock), .chipSelectN(chipSelectN),
    .serialClock(serialClock), .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut));

  function automatic logic [7:0] memData(logic [23:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  // Read data follows the registered address within the same cycle
  assign memRdData = memData(memRdAddr);
  function automatic logic prot(logic [2:0] p, logic [2:0] s);
    return p[2] || (p == 3'h1 && s == 3'h7) ||
           (p == 3'h2 && s >= 3'h6) || (p == 3'h3 && s[2]);
  endfunction
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic frame(input int extra);
    logic [7:0] r;
    logic       b;
    rx.delete();
    host.select();
    foreach (tx[i]) begin
      host.shiftByte(tx[i], r);
      rx.push_back(r);
    end
    for (int i = 0; i < extra; i++) host.shiftBit(1'b0, b);
    host.deselect();
    tx.delete();
  endtask
  task automatic op1(input logic [7:0] c);
    tx = '{c};
    frame(0);
  endtask
  task automatic readStatus(input logic [7:0] exp);
    tx = '{8'h05, 8'h00, 8'h00};
    frame(0);
    chk("status", rx[1], exp);
    chk("statusAgain", rx[2], exp);
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    while (flashStatus[0] !== 1'b0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    chk("busyEnd", flashStatus[0], 1'b0);
  endtask
  task automatic setProt(input logic [2:0] p);
    op1(8'h06);
    tx = '{8'h01, {3'h0, p, 2'h0}};
    frame(0);
    waitIdle();
    chk("protect", flashStatus, {3'h0, p, 2'h0});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Memory with random stalls, result monitor and hang guard
  always @(posedge clock) begin
    memWrReady <= 1'($random(seed));
    cycles <= cycles + 1;
    if (memWrValid && memWrReady)
      chk("memWr", {memWrAddr, memWrData},
          expW.size() ? expW.pop_front() : 32'hx);
    if (eraseValid)
      chk("erase", {eraseAll, eraseSector},
          expE.size() ? expE.pop_front() : 4'hx);
    if (cycles == 90000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk("resetStatus", flashStatus, `SFCI_STATUS_RESET);
    op1(8'h06);
    readStatus(8'h02);
    op1(8'h9f);
    readStatus(8'h02);
    op1(8'h04);
    readStatus(8'h00);
    tx = '{8'h01, 8'hff};
    frame(0);
    readStatus(8'h00);
    op1(8'h06);
    tx = '{8'h01, 8'hff};
    frame(1);
    readStatus(8'h02);
    tx = '{8'h01, 8'hff};
    frame(0);
    tx = '{8'h05, 8'h00};
    frame(0);
    chk("busyBit", rx[1][0], 1'b1);
    tx = '{8'h03, 8'h00, 8'h12, 8'hfe, 8'h00};
    frame(0);
    chk("busyRead", rx[4], 8'h00);
    waitIdle();
    chk("wrStatus", flashStatus, 8'h1c);
    op1(8'h06);
    op1(8'hc7);
    for (int p = 0; p < 8; p++) begin
      setProt(p[2:0]);
      for (int s = 0; s < 8; s++) begin
        if (!prot(p[2:0], s[2:0]))
          expE.push_back({1'b0, s[2:0]});
        op1(8'h06);
        tx = '{8'hd8, {5'h0, s[2:0]}, 8'h00, 8'h00};
        frame(0);
        waitIdle();
      end
    end
    setProt(3'h0);
    op1(8'h06);
    expE.push_back(4'h8);
    op1(8'hc7);
    waitIdle();
    readStatus(8'h00);
    op1(8'h04);
    tx = '{8'h02, 8'h01, 8'h23, 8'hff, 8'haa};
    frame(0);
    op1(8'h06);
    expW.push_back(32'h01230055);
    expW.push_back(32'h0123ffaa);
    tx = '{8'h02, 8'h01, 8'h23, 8'hff, 8'haa, 8'h55};
    frame(0);
    waitIdle();
    op1(8'h06);
    tx = '{8'h02, 8'h02, 8'h00, 8'h00};
    for (int i = 0; i < 258; i++) tx.push_back(8'(i >> 1));
    for (int c = 0; c < 256; c++)
      expW.push_back({16'h0200, 8'(c), 8'((c < 2 ? c + 256 : c) >> 1)});
    frame(0);
    waitIdle();
    tx = '{8'h03, 8'h00, 8'h12, 8'hfe, 8'h00, 8'h00, 8'h00};
    frame(0);
    for (int k = 0; k < 3; k++)
      chk("readData", rx[4+k], memData(24'h0012fe + k));
    tx = '{8'hab, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    frame(0);
    chk("ident", rx[4], ID);
    chk("identAgain", rx[5], ID);
    tx = '{8'h05};
    frame(3);
    tx = '{8'h06};
    frame(3);
    readStatus(8'h00);
    chk("pendingWr", expW.size(), 0);
    chk("pendingErase", expE.size(), 0);
    conclude();
  end
endmodule // sfci_flash_if_tb_top
`default_nettype wire
